// File: design/irq_enable_consts.vh
// Constants for the interrupt enable mask block
`ifndef IRQ_ENABLE_CONSTS_VH
`define IRQ_ENABLE_CONSTS_VH

// Register byte addresses
`define ADDR_IRQ_ENABLE_MASK   4'h0
`define ADDR_IRQ_EVENT_STATUS  4'h4
`define ADDR_IRQ_PENDING       4'h8

// Reset value of the enable mask
`define IRQ_ENABLE_RESET       16'h0000

// Enable bit positions
`define BIT_RX_FIFO_OVERRUN    0
`define BIT_MISSED_TALLY       1
`define BIT_ALIGN_TALLY        2
`define BIT_CRC_TALLY          3
`define BIT_RX_AREA_EXCEEDED   4
`define BIT_RX_BUFFERS_EXH     5
`define BIT_RX_DESCRIPTOR      6
`define BIT_TIMER_DONE         7
`define BIT_TX_ERROR           8
`define BIT_TX_DONE            9
`define BIT_RX_PACKET          10
`define BIT_PROGRAMMABLE       11
`define BIT_FILTER_LOAD_DONE   12
`define BIT_HEARTBEAT_LOST     13
`define BIT_BUS_RETRY          14
`define BIT_MUST_BE_ZERO       15

// Mask of bits that can be written
`define IRQ_ENABLE_WMASK       16'h7FFF

// AXI responses
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2

`endif

// File: design/event_latch.v
// Sticky event latch, set wins over clear
`default_nettype none
module event_latch #(
  parameter WIDTH = 15
) (
  // Clock and reset
  input  wire             aclk,
  input  wire             aresetn,
  // Events and clear
  input  wire [WIDTH-1:0] event_in,
  input  wire [WIDTH-1:0] clear_in,
  // Latched state
  output reg  [WIDTH-1:0] latched
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always @(posedge aclk) begin
        if (!aresetn)
          latched[i] <= 1'b0;
        else if (event_in[i])
          latched[i] <= 1'b1;
        else if (clear_in[i])
          latched[i] <= 1'b0;
      end
    end
  endgenerate
endmodule
`default_nettype wire

// File: design/interrupt_enable_mask.v
// Interrupt enable mask register with AXI4-Lite access and gated interrupt output
//
// How it works
// - Bit 14 enables interrupt on bus retry requests.
// - Bit 13 enables interrupt on heartbeat lost.
// - Bit 12 enables interrupt when address filter load completes.
// - Bit 11 enables interrupt for descriptors with programmable flag set.
// - Bit 10 enables interrupt for each accepted received packet.
// - Bit 9 enables interrupt on successful transmit completion.
// - Bit 8 enables interrupt on transmit errors.
// - An enable gates the CRC tally warning interrupt.
// - An enable gates the alignment tally warning interrupt.
// - An enable gates the missed packet tally warning interrupt.
// - Separate enables gate buffers exhausted and buffer area exceeded.
// - An enable gates the receive FIFO overrun interrupt.
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`default_nettype none
`include "irq_enable_consts.vh"
module interrupt_enable_mask #(
  parameter ADDR_WIDTH = 4
) (
  // Clock and reset
  input  wire                  aclk,
  input  wire                  aresetn,
  // AXI4-Lite write address
  input  wire [ADDR_WIDTH-1:0] s_axi_awaddr,
  input  wire                  s_axi_awvalid,
  output reg                   s_axi_awready,
  // AXI4-Lite write data
  input  wire [31:0]           s_axi_wdata,
  input  wire [3:0]            s_axi_wstrb,
  input  wire                  s_axi_wvalid,
  output reg                   s_axi_wready,
  // AXI4-Lite write response
  output reg  [1:0]            s_axi_bresp,
  output reg                   s_axi_bvalid,
  input  wire                  s_axi_bready,
  // AXI4-Lite read address
  input  wire [ADDR_WIDTH-1:0] s_axi_araddr,
  input  wire                  s_axi_arvalid,
  output reg                   s_axi_arready,
  // AXI4-Lite read data
  output reg  [31:0]           s_axi_rdata,
  output reg  [1:0]            s_axi_rresp,
  output reg                   s_axi_rvalid,
  input  wire                  s_axi_rready,
  // Event pulses from the controller
  input  wire                  bus_retry_evt,
  input  wire                  heartbeat_lost_evt,
  input  wire                  filter_load_done_evt,
  input  wire                  descriptor_done_evt,
  input  wire                  descriptor_irq_flag,
  input  wire                  rx_packet_evt,
  input  wire                  tx_done_evt,
  input  wire                  tx_error_evt,
  input  wire                  timer_done_evt,
  input  wire                  rx_descriptor_evt,
  input  wire                  rx_buffers_exhausted_evt,
  input  wire                  rx_area_exceeded_evt,
  input  wire                  crc_tally_warn_evt,
  input  wire                  align_tally_warn_evt,
  input  wire                  missed_tally_warn_evt,
  input  wire                  rx_fifo_overrun_evt,
  // Enable bits and interrupt
  output reg  [15:0]           enable_mask_out,
  output reg                   irq
);

  reg  [15:0] enable_mask;
  wire [14:0] events;
  wire [14:0] status;
  wire [14:0] pending;
  reg  [14:0] status_clear;

  // Field names of the enable register
  wire bus_retry_irq_en            = enable_mask[`BIT_BUS_RETRY];
  wire heartbeat_lost_irq_en       = enable_mask[`BIT_HEARTBEAT_LOST];
  wire filter_load_done_irq_en     = enable_mask[`BIT_FILTER_LOAD_DONE];
  wire programmable_irq_en         = enable_mask[`BIT_PROGRAMMABLE];
  wire rx_packet_irq_en            = enable_mask[`BIT_RX_PACKET];
  wire tx_done_irq_en              = enable_mask[`BIT_TX_DONE];
  wire tx_error_irq_en             = enable_mask[`BIT_TX_ERROR];
  wire timer_done_irq_en           = enable_mask[`BIT_TIMER_DONE];
  wire rx_descriptor_irq_en        = enable_mask[`BIT_RX_DESCRIPTOR];
  wire rx_buffers_exhausted_irq_en = enable_mask[`BIT_RX_BUFFERS_EXH];
  wire rx_area_exceeded_irq_en     = enable_mask[`BIT_RX_AREA_EXCEEDED];
  wire crc_tally_warn_irq_en       = enable_mask[`BIT_CRC_TALLY];
  wire align_tally_warn_irq_en     = enable_mask[`BIT_ALIGN_TALLY];
  wire missed_tally_warn_irq_en    = enable_mask[`BIT_MISSED_TALLY];
  wire rx_fifo_overrun_irq_en      = enable_mask[`BIT_RX_FIFO_OVERRUN];

  // Raw event vector in enable-bit order
  assign events[`BIT_BUS_RETRY]        = bus_retry_evt;
  assign events[`BIT_HEARTBEAT_LOST]   = heartbeat_lost_evt;
  assign events[`BIT_FILTER_LOAD_DONE] = filter_load_done_evt;
  // Only descriptors carrying the flag count
  assign events[`BIT_PROGRAMMABLE]     = descriptor_done_evt & descriptor_irq_flag;
  assign events[`BIT_RX_PACKET]        = rx_packet_evt;
  assign events[`BIT_TX_DONE]          = tx_done_evt;
  assign events[`BIT_TX_ERROR]         = tx_error_evt;
  assign events[`BIT_TIMER_DONE]       = timer_done_evt;
  assign events[`BIT_RX_DESCRIPTOR]    = rx_descriptor_evt;
  assign events[`BIT_RX_BUFFERS_EXH]   = rx_buffers_exhausted_evt;
  assign events[`BIT_RX_AREA_EXCEEDED] = rx_area_exceeded_evt;
  assign events[`BIT_CRC_TALLY]        = crc_tally_warn_evt;
  assign events[`BIT_ALIGN_TALLY]      = align_tally_warn_evt;
  assign events[`BIT_MISSED_TALLY]     = missed_tally_warn_evt;
  assign events[`BIT_RX_FIFO_OVERRUN]  = rx_fifo_overrun_evt;

  // Sticky status of every event, enabled or not
  event_latch #(
    .WIDTH (15)
  ) u_status (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .event_in (events),
    .clear_in (status_clear),
    .latched  (status)
  );

  // Gating of each latched event by its enable
  assign pending[`BIT_BUS_RETRY]        = status[`BIT_BUS_RETRY] & bus_retry_irq_en;
  assign pending[`BIT_HEARTBEAT_LOST]   = status[`BIT_HEARTBEAT_LOST] & heartbeat_lost_irq_en;
  assign pending[`BIT_FILTER_LOAD_DONE] = status[`BIT_FILTER_LOAD_DONE] & filter_load_done_irq_en;
  assign pending[`BIT_PROGRAMMABLE]     = status[`BIT_PROGRAMMABLE] & programmable_irq_en;
  assign pending[`BIT_RX_PACKET]        = status[`BIT_RX_PACKET] & rx_packet_irq_en;
  assign pending[`BIT_TX_DONE]          = status[`BIT_TX_DONE] & tx_done_irq_en;
  assign pending[`BIT_TX_ERROR]         = status[`BIT_TX_ERROR] & tx_error_irq_en;
  assign pending[`BIT_TIMER_DONE]       = status[`BIT_TIMER_DONE] & timer_done_irq_en;
  assign pending[`BIT_RX_DESCRIPTOR]    = status[`BIT_RX_DESCRIPTOR] & rx_descriptor_irq_en;
  assign pending[`BIT_CRC_TALLY]        = status[`BIT_CRC_TALLY] & crc_tally_warn_irq_en;
  assign pending[`BIT_ALIGN_TALLY]      = status[`BIT_ALIGN_TALLY] & align_tally_warn_irq_en;
  assign pending[`BIT_MISSED_TALLY]     = status[`BIT_MISSED_TALLY] & missed_tally_warn_irq_en;
  assign pending[`BIT_RX_BUFFERS_EXH]   = status[`BIT_RX_BUFFERS_EXH] & rx_buffers_exhausted_irq_en;
  assign pending[`BIT_RX_AREA_EXCEEDED] = status[`BIT_RX_AREA_EXCEEDED] & rx_area_exceeded_irq_en;
  assign pending[`BIT_RX_FIFO_OVERRUN]  = status[`BIT_RX_FIFO_OVERRUN] & rx_fifo_overrun_irq_en;

  // Full byte address decode, shared by both channels
  function [1:0] reg_index;
    input [ADDR_WIDTH-1:0] addr;
    begin
      case (addr)
        `ADDR_IRQ_ENABLE_MASK:  reg_index = 2'h1;
        `ADDR_IRQ_EVENT_STATUS: reg_index = 2'h2;
        `ADDR_IRQ_PENDING:      reg_index = 2'h3;
        default:                reg_index = 2'h0;
      endcase
    end
  endfunction

  // Write channel: address and data latched in either order
  reg                  aw_held;
  reg                  w_held;
  reg [ADDR_WIDTH-1:0] aw_addr;
  reg [31:0]           w_data;
  reg [3:0]            w_strb;
  wire                 do_write = aw_held & w_held & ~s_axi_bvalid;
  wire [1:0]           wr_index = reg_index(aw_addr);
  wire [15:0]          strb_bits = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= {ADDR_WIDTH{1'b0}};
      w_data        <= 32'h00000000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_held & ~s_axi_awready & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held & ~s_axi_wready & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_index == 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Enable register; bit 15 is forced to zero
  always @(posedge aclk) begin
    if (!aresetn)
      enable_mask <= `IRQ_ENABLE_RESET;
    else if (do_write && wr_index == 2'h1)
      enable_mask <= ((enable_mask & ~strb_bits) | (w_data[15:0] & strb_bits)) & `IRQ_ENABLE_WMASK;
  end

  // Write one to a status bit clears it
  always @* begin
    status_clear = 15'h0000;
    if (do_write && wr_index == 2'h2)
      status_clear = w_data[14:0] & strb_bits[14:0];
  end

  // Read channel
  reg [15:0] rd_value;
  wire [1:0] rd_index = reg_index(s_axi_araddr);

  always @* begin
    case (rd_index)
      2'h1:    rd_value = enable_mask;
      2'h2:    rd_value = {1'b0, status};
      2'h3:    rd_value = {1'b0, pending};
      default: rd_value = 16'h0000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rd_value};
        s_axi_rresp  <= (rd_index == 2'h0) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Registered outputs
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq             <= 1'b0;
      enable_mask_out <= `IRQ_ENABLE_RESET;
    end else begin
      irq             <= |pending;
      enable_mask_out <= enable_mask;
    end
  end

endmodule
`default_nettype wire

// File: test/irq_mask_sva.sv
// Assertions on the enable mask outputs and the gated interrupt
`default_nettype none
module irq_mask_sva (
  // Clock, reset and write data handshake
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  // Event inputs
  input wire logic        bus_retry_evt,
  input wire logic        heartbeat_lost_evt,
  input wire logic        filter_load_done_evt,
  input wire logic        descriptor_done_evt,
  input wire logic        descriptor_irq_flag,
  input wire logic        rx_packet_evt,
  input wire logic        tx_done_evt,
  input wire logic        tx_error_evt,
  input wire logic        timer_done_evt,
  input wire logic        rx_descriptor_evt,
  input wire logic        rx_buffers_exhausted_evt,
  input wire logic        rx_area_exceeded_evt,
  input wire logic        crc_tally_warn_evt,
  input wire logic        align_tally_warn_evt,
  input wire logic        missed_tally_warn_evt,
  input wire logic        rx_fifo_overrun_evt,
  // Enable copy and interrupt
  input wire logic [15:0] enable_mask_out,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [14:0] ev = {bus_retry_evt, heartbeat_lost_evt, filter_load_done_evt,
    descriptor_done_evt & descriptor_irq_flag, rx_packet_evt, tx_done_evt, tx_error_evt, timer_done_evt,
    rx_descriptor_evt, rx_buffers_exhausted_evt, rx_area_exceeded_evt, crc_tally_warn_evt,
    align_tally_warn_evt, missed_tally_warn_evt, rx_fifo_overrun_evt};
  // No write in flight that could clear status
  wire        quiet = !(s_axi_wvalid && s_axi_wready);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_armed(int b);
    ev[b] && enable_mask_out[b] && quiet ##1 enable_mask_out[b] && quiet ##1 enable_mask_out[b];
  endsequence
  property p_gate(int b);
    s_armed(b) |-> irq;
  endproperty
  bus_retry_a: assert property (p_gate(14)) else $error("bus retry event gave no interrupt");
  heartbeat_lost_a: assert property (p_gate(13)) else $error("heartbeat event gave no interrupt");
  filter_done_a: assert property (p_gate(12)) else $error("filter load event gave no interrupt");
  desc_flag_a: assert property (p_gate(11)) else $error("descriptor event gave no interrupt");
  rx_packet_a: assert property (p_gate(10)) else $error("rx packet event gave no interrupt");
  tx_done_a: assert property (p_gate(9)) else $error("tx done event gave no interrupt");
  tx_error_a: assert property (p_gate(8)) else $error("tx error event gave no interrupt");
  crc_warn_a: assert property (p_gate(3)) else $error("crc warning gave no interrupt");
  align_warn_a: assert property (p_gate(2)) else $error("align warning gave no interrupt");
  missed_warn_a: assert property (p_gate(1)) else $error("missed warning gave no interrupt");
  rx_exhausted_a: assert property (p_gate(5)) else $error("buffers exhausted gave no interrupt");
  rx_area_a: assert property (p_gate(4)) else $error("area exceeded gave no interrupt");
  fifo_overrun_a: assert property (p_gate(0)) else $error("fifo overrun gave no interrupt");
  mask_off_quiet_a: assert property (enable_mask_out == 16'h0000 [*3] |-> !irq) else $error("irq with no enables");
  top_bit_zero_a: assert property (!enable_mask_out[15]) else $error("bit 15 of enable set");
endmodule
bind interrupt_enable_mask irq_mask_sva i_irq_mask_sva (.aclk(aclk), .aresetn(aresetn),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .bus_retry_evt(bus_retry_evt),
  .heartbeat_lost_evt(heartbeat_lost_evt), .filter_load_done_evt(filter_load_done_evt),
  .descriptor_done_evt(descriptor_done_evt), .descriptor_irq_flag(descriptor_irq_flag),
  .rx_packet_evt(rx_packet_evt), .tx_done_evt(tx_done_evt), .tx_error_evt(tx_error_evt),
  .timer_done_evt(timer_done_evt), .rx_descriptor_evt(rx_descriptor_evt),
  .rx_buffers_exhausted_evt(rx_buffers_exhausted_evt), .rx_area_exceeded_evt(rx_area_exceeded_evt),
  .crc_tally_warn_evt(crc_tally_warn_evt), .align_tally_warn_evt(align_tally_warn_evt),
  .missed_tally_warn_evt(missed_tally_warn_evt), .rx_fifo_overrun_evt(rx_fifo_overrun_evt),
  .enable_mask_out(enable_mask_out), .irq(irq));
`default_nettype wire

// File: test/test_interrupt_enable_mask.sv
// Self-checking bench for the interrupt enable mask block
`default_nettype none
`include "irq_enable_consts.vh"
module test_interrupt_enable_mask;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hF;
  logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, flag = 1'h1;
  logic [31:0] wdata = 32'h0, rd;
  logic [14:0] ev = 15'h0;
  logic [1:0]  resp;
  wire         awready, wready, bvalid, arready, rvalid, irq;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [15:0] mask_out;
  int          fails = 0, checks = 0, cycles = 0;
  interrupt_enable_mask #(.ADDR_WIDTH(4)) i_interrupt_enable_mask (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .bus_retry_evt(ev[14]), .heartbeat_lost_evt(ev[13]), .filter_load_done_evt(ev[12]),
    .descriptor_done_evt(ev[11]), .descriptor_irq_flag(flag), .rx_packet_evt(ev[10]), .tx_done_evt(ev[9]),
    .tx_error_evt(ev[8]), .timer_done_evt(ev[7]), .rx_descriptor_evt(ev[6]), .rx_buffers_exhausted_evt(ev[5]),
    .rx_area_exceeded_evt(ev[4]), .crc_tally_warn_evt(ev[3]), .align_tally_warn_evt(ev[2]),
    .missed_tally_warn_evt(ev[1]), .rx_fifo_overrun_evt(ev[0]), .enable_mask_out(mask_out), .irq(irq));
  initial begin
    forever #4 aclk = ~aclk;
  end
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
    @(posedge aclk);
  endtask
  task automatic axr(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rd = rdata;
    resp = rresp;
    rready <= 1'h0;
    @(posedge aclk);
  endtask
  // One-cycle event, then time for irq to follow
  task automatic pulse(input int b, input logic f);
    flag <= f;
    ev <= 15'h0001 << b;
    @(posedge aclk);
    ev <= 15'h0000;
    flag <= 1'h1;
    repeat (3) @(posedge aclk);
  endtask
  task automatic test_reset();
    axr(`ADDR_IRQ_ENABLE_MASK);
    chk("enable reset", {16'h0000, `IRQ_ENABLE_RESET}, rd);
    chk("irq reset", 32'h0, {31'h0, irq});
    $display("test_reset done");
  endtask
  task automatic test_access();
    axw(`ADDR_IRQ_ENABLE_MASK, 32'hFFFFFFFF);
    chk("write resp", {30'h0, `RESP_OKAY}, {30'h0, resp});
    axr(`ADDR_IRQ_ENABLE_MASK);
    chk("enable all", 32'h00007FFF, rd);
    chk("mask copy", 32'h00007FFF, {16'h0000, mask_out});
    wstrb <= 4'h1;
    axw(`ADDR_IRQ_ENABLE_MASK, 32'h00000000);
    wstrb <= 4'hF;
    axr(`ADDR_IRQ_ENABLE_MASK);
    chk("low byte strobe", 32'h00007F00, rd);
    axw(4'hC, 32'h0000FFFF);
    chk("unmapped write", {30'h0, `RESP_SLVERR}, {30'h0, resp});
    axr(4'hC);
    chk("unmapped read", {30'h0, `RESP_SLVERR}, {30'h0, resp});
    chk("unmapped data", 32'h0, rd);
    axw(`ADDR_IRQ_PENDING, 32'h00000000);
    chk("pending write", {30'h0, `RESP_OKAY}, {30'h0, resp});
    $display("test_access done");
  endtask
  task automatic test_gate();
    for (int b = 0; b < 15; b++) begin
      axw(`ADDR_IRQ_ENABLE_MASK, 32'h1 << b);
      axw(`ADDR_IRQ_EVENT_STATUS, 32'h00007FFF);
      pulse(b, 1'h1);
      chk("irq enabled", 32'h1, {31'h0, irq});
      axr(`ADDR_IRQ_EVENT_STATUS);
      chk("status set", 32'h1 << b, rd);
      axr(`ADDR_IRQ_PENDING);
      chk("pending set", 32'h1 << b, rd);
      axw(`ADDR_IRQ_EVENT_STATUS, 32'h00007FFF);
      pulse(b, 1'h0);
      chk("irq flag low", {31'h0, b != 11}, {31'h0, irq});
      axw(`ADDR_IRQ_ENABLE_MASK, 32'h00007FFF ^ (32'h1 << b));
      axw(`ADDR_IRQ_EVENT_STATUS, 32'h00007FFF);
      pulse(b, 1'h1);
      chk("irq masked", 32'h0, {31'h0, irq});
      axr(`ADDR_IRQ_EVENT_STATUS);
      chk("status masked", 32'h1 << b, rd);
      axr(`ADDR_IRQ_PENDING);
      chk("pending masked", 32'h0, rd);
    end
    $display("test_gate done");
  endtask
  // Reset in mid-run clears enables, status and irq
  task automatic test_midreset();
    axw(`ADDR_IRQ_ENABLE_MASK, 32'h00007FFF);
    pulse(0, 1'h1);
    chk("irq before reset", 32'h1, {31'h0, irq});
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    chk("irq after reset", 32'h0, {31'h0, irq});
    chk("mask after reset", {16'h0000, `IRQ_ENABLE_RESET}, {16'h0000, mask_out});
    axr(`ADDR_IRQ_EVENT_STATUS);
    chk("status after reset", 32'h0, rd);
    axr(`ADDR_IRQ_ENABLE_MASK);
    chk("enable after reset", {16'h0000, `IRQ_ENABLE_RESET}, rd);
    $display("test_midreset done");
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    test_reset();
    test_access();
    test_gate();
    test_midreset();
    stop_test();
  end
endmodule
`default_nettype wire
